//--- hw/clock_monitor_alarm_config_pkg.sv
// Function
// RULE_01: Bit 1 powers down second input buffer.
// RULE_02: Bit 0 powers down first input buffer.
// RULE_03: Global enable gates each per-input offset monitor.
// RULE_04: Two-bit field selects offset alarm threshold.
// RULE_05: Clock valid for programmed time clears alarm.
// RULE_06: Phase slip retriggers lock-loss one-shot interval.
// RULE_07: Software uses retrigger code 001 during calibration.
// RULE_08: Pin enable drives lock-loss status, else tristate. Code holds lock_loss_pin_oe at 0 from reset until the first enabled clock.
// RULE_09: Pin enable drives interrupt status, else disabled.
// RULE_10: Monitoring register resets to 0x2c.
// RULE_11: Power-down register resets to 0x40.
// RULE_12: Polarity bit sets lock-loss pin active level.
// RULE_13: Polarity bit sets interrupt pin active level.
// RULE_14: Invalid again restarts validation, alarm stays.
// RULE_15: Reserved bits read fixed, writes ignored.
package clock_monitor_alarm_config_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INPUT_BUFFER_POWERDOWN = 8'h0b;
  localparam logic [7:0] ADDR_MONITOR_TIMING_CONFIG = 8'h13;
  localparam logic [7:0] ADDR_ALARM_PIN_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_ALARM_PIN_POLARITY = 8'h16;

  localparam logic [7:0] RST_INPUT_BUFFER_POWERDOWN = 8'h40;
  localparam logic [7:0] RST_MONITOR_TIMING_CONFIG = 8'h2c;
  localparam logic [7:0] RST_ALARM_PIN_ENABLE = 8'h3e;
  localparam logic [7:0] RST_ALARM_PIN_POLARITY = 8'hdf;

  // Fixed read values of the bits that are not stored
  localparam logic [5:0] FIXED_POWERDOWN_HI = 6'h10;
  localparam logic [5:0] FIXED_PIN_ENABLE_HI = 6'h0f;
  localparam logic [5:0] FIXED_POLARITY_HI = 6'h37;

  localparam int POS_FIRST_PD = 0;
  localparam int POS_SECOND_PD = 1;
  localparam int POS_IRQ_EN = 0;
  localparam int POS_LOSS_EN = 1;
  localparam int POS_IRQ_POL = 0;
  localparam int POS_LOSS_POL = 1;

  typedef struct packed {
    logic offset_monitor_global_enable;
    logic [1:0] offset_threshold_select;
    logic [1:0] clock_validation_time;
    logic [2:0] lock_loss_retrigger_interval;
  } monitor_cfg_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int VALID_TIME_US [4] = '{2000, 100000, 200000, 13000000};
  localparam int RETRIG_US_X1000 [8] = '{106000000, 53000000, 26500000, 13300000,
                                         6600000, 3300000, 1660000, 833000};
  localparam int CNT_W = 30;

  function automatic int unsigned us_to_cyc(input int unsigned us);
    return us * CLK_MHZ;
  endfunction

  function automatic int unsigned nus_to_cyc(input int unsigned us_x1000);
    return (us_x1000 / 1000) * CLK_MHZ + ((us_x1000 % 1000) * CLK_MHZ) / 1000;
  endfunction

endpackage

//--- hw/clock_monitor_alarm_config.sv
`timescale 1ns/10ps
module clock_monitor_alarm_config #(
  parameter int unsigned VAL_CYC [4] = '{
    clock_monitor_alarm_config_pkg::us_to_cyc(clock_monitor_alarm_config_pkg::VALID_TIME_US[0]),
    clock_monitor_alarm_config_pkg::us_to_cyc(clock_monitor_alarm_config_pkg::VALID_TIME_US[1]),
    clock_monitor_alarm_config_pkg::us_to_cyc(clock_monitor_alarm_config_pkg::VALID_TIME_US[2]),
    clock_monitor_alarm_config_pkg::us_to_cyc(clock_monitor_alarm_config_pkg::VALID_TIME_US[3])},
  parameter int unsigned RETRIG_CYC [8] = '{
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[0]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[1]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[2]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[3]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[4]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[5]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[6]),
    clock_monitor_alarm_config_pkg::nus_to_cyc(clock_monitor_alarm_config_pkg::RETRIG_US_X1000[7])}
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] clock_invalid,
  input wire logic [1:0] offset_monitor_input_enable,
  input wire logic [1:0] frequency_offset_detect,
  input wire logic phase_slip,
  input wire logic interrupt_status,
  output logic first_input_powerdown,
  output logic second_input_powerdown,
  output logic [1:0] offset_monitor_active,
  output logic [1:0] offset_threshold_select,
  output logic [1:0] frequency_offset_alarm,
  output logic [1:0] clock_alarm,
  output logic lock_loss_status,
  output logic lock_loss_pin_out,
  output logic lock_loss_pin_oe,
  output logic interrupt_output_pin_out,
  output logic interrupt_output_pin_oe
);

  localparam int W = clock_monitor_alarm_config_pkg::CNT_W;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0] pd_ff;
  logic [1:0] nxt_pd;
  clock_monitor_alarm_config_pkg::monitor_cfg_t cfg_ff;
  clock_monitor_alarm_config_pkg::monitor_cfg_t nxt_cfg;
  logic [1:0] pin_en_ff;
  logic [1:0] nxt_pin_en;
  logic [1:0] pol_ff;
  logic [1:0] nxt_pol;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb
  begin
    nxt_pd = pd_ff;
    nxt_cfg = cfg_ff;
    nxt_pin_en = pin_en_ff;
    nxt_pol = pol_ff;
    if (reg_wr)
    begin
      // Only the stored bits take write data; the rest stay fixed  // see RULE_15
      case (reg_addr)
        clock_monitor_alarm_config_pkg::ADDR_INPUT_BUFFER_POWERDOWN:
          nxt_pd = reg_wdata[1:0];
        clock_monitor_alarm_config_pkg::ADDR_MONITOR_TIMING_CONFIG:
          nxt_cfg = reg_wdata;
        clock_monitor_alarm_config_pkg::ADDR_ALARM_PIN_ENABLE:
          nxt_pin_en = reg_wdata[1:0];
        clock_monitor_alarm_config_pkg::ADDR_ALARM_PIN_POLARITY:
          nxt_pol = reg_wdata[1:0];
        default:
          nxt_pd = pd_ff;
      endcase
    end
  end

  always_comb
  begin
    case (reg_addr)
      clock_monitor_alarm_config_pkg::ADDR_INPUT_BUFFER_POWERDOWN:
        nxt_rdata = {clock_monitor_alarm_config_pkg::FIXED_POWERDOWN_HI, nxt_pd};  // see RULE_15
      clock_monitor_alarm_config_pkg::ADDR_MONITOR_TIMING_CONFIG:
        nxt_rdata = nxt_cfg;
      clock_monitor_alarm_config_pkg::ADDR_ALARM_PIN_ENABLE:
        nxt_rdata = {clock_monitor_alarm_config_pkg::FIXED_PIN_ENABLE_HI, nxt_pin_en};
      clock_monitor_alarm_config_pkg::ADDR_ALARM_PIN_POLARITY:
        nxt_rdata = {clock_monitor_alarm_config_pkg::FIXED_POLARITY_HI, nxt_pol};
      default:
        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pd_ff <= clock_monitor_alarm_config_pkg::RST_INPUT_BUFFER_POWERDOWN[1:0];  // see RULE_11
      cfg_ff <= clock_monitor_alarm_config_pkg::RST_MONITOR_TIMING_CONFIG;  // see RULE_10
      pin_en_ff <= clock_monitor_alarm_config_pkg::RST_ALARM_PIN_ENABLE[1:0];
      pol_ff <= clock_monitor_alarm_config_pkg::RST_ALARM_PIN_POLARITY[1:0];
      rdata_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      pd_ff <= nxt_pd;
      cfg_ff <= nxt_cfg;
      pin_en_ff <= nxt_pin_en;
      pol_ff <= nxt_pol;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Clock validation timers
  // ----------------------------------------------------------------
  // Alarms start asserted: no input is trusted until it proves valid.
  logic [1:0] alarm_ff;
  logic [1:0] nxt_alarm;
  logic [W-1:0] val_cnt_ff [2];
  logic [W-1:0] nxt_val_cnt [2];
  logic [W-1:0] val_limit;

  always_comb
  begin
    val_limit = W'(VAL_CYC[cfg_ff.clock_validation_time] - 1);  // see RULE_05
    for (int i = 0; i < 2; i++)
    begin
      nxt_alarm[i] = alarm_ff[i];
      nxt_val_cnt[i] = val_cnt_ff[i];
      if (clock_invalid[i])
      begin
        nxt_alarm[i] = 1'b1;  // see RULE_14
        nxt_val_cnt[i] = '0;  // see RULE_14
      end
      else if (alarm_ff[i])
      begin
        if (val_cnt_ff[i] >= val_limit)
        begin
          nxt_alarm[i] = 1'b0;  // see RULE_05
          nxt_val_cnt[i] = '0;
        end
        else
          nxt_val_cnt[i] = val_cnt_ff[i] + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alarm_ff <= 2'h3;
      val_cnt_ff[0] <= '0;
      val_cnt_ff[1] <= '0;
    end
    else if (clk_en)
    begin
      alarm_ff <= nxt_alarm;
      val_cnt_ff[0] <= nxt_val_cnt[0];
      val_cnt_ff[1] <= nxt_val_cnt[1];
    end
  end

  // ----------------------------------------------------------------
  // Lock-loss one-shot
  // ----------------------------------------------------------------
  // A new slip reloads the full interval, so lock loss holds until
  // a whole quiet interval has passed.
  logic [W-1:0] slip_cnt_ff;
  logic [W-1:0] nxt_slip_cnt;
  logic lock_lost_ff;
  logic nxt_lock_lost;

  always_comb
  begin
    nxt_slip_cnt = slip_cnt_ff;
    if (phase_slip)
      nxt_slip_cnt = W'(RETRIG_CYC[cfg_ff.lock_loss_retrigger_interval]);  // see RULE_06
    else if (slip_cnt_ff != '0)
      nxt_slip_cnt = slip_cnt_ff - W'(1);
    nxt_lock_lost = (nxt_slip_cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slip_cnt_ff <= '0;
      lock_lost_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      slip_cnt_ff <= nxt_slip_cnt;
      lock_lost_ff <= nxt_lock_lost;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs and pins
  // ----------------------------------------------------------------
  logic [1:0] buf_pd_ff;
  logic [1:0] nxt_buf_pd;
  logic [1:0] mon_act_ff;
  logic [1:0] nxt_mon_act;
  logic [1:0] thr_ff;
  logic [1:0] nxt_thr;
  logic [1:0] offset_alarm_ff;
  logic [1:0] nxt_offset_alarm;
  logic loss_pin_ff;
  logic nxt_loss_pin;
  logic loss_oe_ff;
  logic nxt_loss_oe;
  logic irq_pin_ff;
  logic nxt_irq_pin;
  logic irq_oe_ff;
  logic nxt_irq_oe;

  // Active high when the polarity bit is 1, active low when 0
  function automatic logic pin_level(input logic status, input logic active_high);
    return ~(status ^ active_high);
  endfunction

  always_comb
  begin
    nxt_buf_pd[0] = nxt_pd[clock_monitor_alarm_config_pkg::POS_FIRST_PD];  // see RULE_02
    nxt_buf_pd[1] = nxt_pd[clock_monitor_alarm_config_pkg::POS_SECOND_PD];  // see RULE_01
    nxt_mon_act = {2{nxt_cfg.offset_monitor_global_enable}} & offset_monitor_input_enable;  // see RULE_03
    nxt_offset_alarm = nxt_mon_act & frequency_offset_detect;  // see RULE_03
    nxt_thr = nxt_cfg.offset_threshold_select;  // see RULE_04
    // The lock-loss pin follows the next state, so it never lags its status flop; the interrupt pin lags interrupt_status by one cycle
    nxt_loss_pin = pin_level(nxt_lock_lost, nxt_pol[clock_monitor_alarm_config_pkg::POS_LOSS_POL]);  // see RULE_12
    nxt_irq_pin = pin_level(interrupt_status, nxt_pol[clock_monitor_alarm_config_pkg::POS_IRQ_POL]);  // see RULE_13
    nxt_loss_oe = nxt_pin_en[clock_monitor_alarm_config_pkg::POS_LOSS_EN];  // see RULE_08
    nxt_irq_oe = nxt_pin_en[clock_monitor_alarm_config_pkg::POS_IRQ_EN];  // see RULE_09
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_pd_ff <= 2'h0;
      mon_act_ff <= 2'h0;
      thr_ff <= clock_monitor_alarm_config_pkg::RST_MONITOR_TIMING_CONFIG[6:5];
      offset_alarm_ff <= 2'h0;
      loss_pin_ff <= 1'b0;
      loss_oe_ff <= 1'b0;
      irq_pin_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      buf_pd_ff <= nxt_buf_pd;
      mon_act_ff <= nxt_mon_act;
      thr_ff <= nxt_thr;
      offset_alarm_ff <= nxt_offset_alarm;
      loss_pin_ff <= nxt_loss_pin;
      loss_oe_ff <= nxt_loss_oe;
      irq_pin_ff <= nxt_irq_pin;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  assign reg_rdata = rdata_ff;
  assign first_input_powerdown = buf_pd_ff[0];
  assign second_input_powerdown = buf_pd_ff[1];
  assign offset_monitor_active = mon_act_ff;
  assign offset_threshold_select = thr_ff;
  assign frequency_offset_alarm = offset_alarm_ff;
  assign clock_alarm = alarm_ff;
  assign lock_loss_status = lock_lost_ff;
  assign lock_loss_pin_out = loss_pin_ff;
  assign lock_loss_pin_oe = loss_oe_ff;
  assign interrupt_output_pin_out = irq_pin_ff;
  assign interrupt_output_pin_oe = irq_oe_ff;

endmodule

//--- tb/clock_monitor_alarm_config_props.sv
`timescale 1ns/10ps
module clock_monitor_alarm_config_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] clock_invalid,
  input wire logic [1:0] offset_monitor_input_enable,
  input wire logic phase_slip,
  input wire logic interrupt_status,
  input wire logic first_input_powerdown,
  input wire logic second_input_powerdown,
  input wire logic [1:0] offset_monitor_active,
  input wire logic [1:0] offset_threshold_select,
  input wire logic [1:0] clock_alarm,
  input wire logic lock_loss_status,
  input wire logic lock_loss_pin_out,
  input wire logic lock_loss_pin_oe,
  input wire logic interrupt_output_pin_out,
  input wire logic interrupt_output_pin_oe
);
  // ----
  // Shadow of the polarity bits, needed to judge the pins
  // ----
  logic [1:0] pol_ff;
  logic [1:0] nxt_pol;
  wire w0b = clk_en && reg_wr && reg_addr == 8'h0b;
  wire w13 = clk_en && reg_wr && reg_addr == 8'h13;
  wire w14 = clk_en && reg_wr && reg_addr == 8'h14;
  assign nxt_pol = (clk_en && reg_wr && reg_addr == 8'h16) ? reg_wdata[1:0] : pol_ff;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) pol_ff <= 2'h3;
    else pol_ff <= nxt_pol;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  pd_second_a:
    assert property (w0b |=> second_input_powerdown == $past(reg_wdata[1]))
    else $error("second powerdown not written");
  pd_first_a:
    assert property (w0b |=> first_input_powerdown == $past(reg_wdata[0]))
    else $error("first powerdown not written");
  mon_gate_a:
    assert property (w13 |=> offset_monitor_active == ($past(reg_wdata[7]) ? $past(offset_monitor_input_enable) : 2'h0))
    else $error("monitor gating wrong");
  thr_copy_a:
    assert property (w13 |=> offset_threshold_select == $past(reg_wdata[6:5]))
    else $error("threshold not written");
  slip_start_a:
    assert property (clk_en && phase_slip |=> lock_loss_status)
    else $error("slip did not start lock loss");
  ll_oe_a:
    assert property (w14 |=> lock_loss_pin_oe == $past(reg_wdata[1]))
    else $error("lock loss pin enable wrong");
  int_oe_a:
    assert property (w14 |=> interrupt_output_pin_oe == $past(reg_wdata[0]))
    else $error("interrupt pin enable wrong");
  ll_pol_a:
    assert property (lock_loss_pin_out == (lock_loss_status == pol_ff[1]))
    else $error("lock loss pin level wrong");
  interrupt_pin_polarity_a:
    assert property (clk_en |=> interrupt_output_pin_out == ($past(interrupt_status) == pol_ff[0]))
    else $error("interrupt pin level wrong");
  val_hold_a:
    assert property (clk_en && clock_invalid[0] |=> clock_alarm[0] ##1 $stable(clock_alarm[0]) || clock_invalid[0])
    else $error("alarm dropped while invalid");
  slip_c: cover property (phase_slip ##1 lock_loss_status);
  cfg_c: cover property (w13);
  inv_c: cover property (clock_invalid[0] ##1 !clock_invalid[0]);
endmodule

//--- tb/tb_clock_monitor_alarm_config.sv
`timescale 1ns/10ps
module tb_clock_monitor_alarm_config;
  localparam int unsigned VC [4] = '{5, 10, 20, 40};
  localparam int unsigned RC [8] = '{16, 14, 12, 10, 8, 6, 4, 2};
  logic sys_clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, phase_slip = 0, interrupt_status = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] clock_invalid = 2'h0, offset_monitor_input_enable = 2'h0, frequency_offset_detect = 2'h0;
  logic [1:0] offset_monitor_active, offset_threshold_select, frequency_offset_alarm, clock_alarm;
  logic first_input_powerdown, second_input_powerdown, lock_loss_status, lock_loss_pin_out;
  logic lock_loss_pin_oe, interrupt_output_pin_out, interrupt_output_pin_oe;
  int miscompares = 0, checked = 0;
  clock_monitor_alarm_config #(.VAL_CYC(VC), .RETRIG_CYC(RC)) dut_u (.sys_clk, .reset_n, .clk_en,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .clock_invalid, .offset_monitor_input_enable,
    .frequency_offset_detect, .phase_slip, .interrupt_status, .first_input_powerdown,
    .second_input_powerdown, .offset_monitor_active, .offset_threshold_select, .frequency_offset_alarm,
    .clock_alarm, .lock_loss_status, .lock_loss_pin_out, .lock_loss_pin_oe, .interrupt_output_pin_out,
    .interrupt_output_pin_oe);
  // ----
  // Shared helpers
  // ----
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rdchk(8'h0b, 8'h40);
    rdchk(8'h13, 8'h2c);
    rdchk(8'h14, 8'h3e);
    rdchk(8'h16, 8'hdf);
    chk("thr", 8'h01, 8'(offset_threshold_select));
    chk("oe", 8'h02, {6'h00, lock_loss_pin_oe, interrupt_output_pin_oe});
  endtask
  task automatic t_regs();
    wr(8'h0b, 8'hff);
    chk("pd", 8'h03, {6'h00, second_input_powerdown, first_input_powerdown});
    wr(8'h0b, 8'h01);
    chk("pd", 8'h01, {6'h00, second_input_powerdown, first_input_powerdown});
    rdchk(8'h0b, 8'h41);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h0b, 8'h02);
    chk("frozen", 8'h01, {6'h00, second_input_powerdown, first_input_powerdown});
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rdchk(8'h0b, 8'h41);
    wr(8'h14, 8'hc0);
    chk("oe", 8'h00, {6'h00, lock_loss_pin_oe, interrupt_output_pin_oe});
    rdchk(8'h14, 8'h3c);
    wr(8'h14, 8'h01);
    chk("oe", 8'h01, {6'h00, lock_loss_pin_oe, interrupt_output_pin_oe});
    wr(8'h30, 8'hff);
    rdchk(8'h30, 8'h00);
    wr(8'h14, 8'h03);
  endtask
  task automatic t_mon();
    @(posedge sys_clk);
    offset_monitor_input_enable <= 2'h3;
    frequency_offset_detect <= 2'h3;
    wr(8'h13, 8'h2c);
    chk("act", 8'h00, 8'(offset_monitor_active));
    wr(8'h13, 8'hac);
    chk("act", 8'h03, 8'(offset_monitor_active));
    @(posedge sys_clk);
    offset_monitor_input_enable <= 2'h1;
    @(posedge sys_clk);
    #1;
    chk("alarm", 8'h01, 8'(frequency_offset_alarm));
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h13, {1'b1, 2'(t), 5'h0c});
      chk("thr", 8'(t), 8'(offset_threshold_select));
    end
  endtask
  // Optional glitch re-invalidates two cycles before the count would end
  task automatic t_val(input int c, input bit g);
    int n;
    wr(8'h13, {3'h1, 2'(c), 3'h4});
    @(posedge sys_clk);
    clock_invalid <= 2'h1;
    @(posedge sys_clk);
    clock_invalid <= 2'h0;
    if (g)
    begin
      repeat (VC[c] - 2) @(posedge sys_clk);
      clock_invalid <= 2'h1;
      @(posedge sys_clk);
      clock_invalid <= 2'h0;
    end
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (clock_alarm[0] === 1'b1 && n < 200);
    chk("valid", 8'(VC[c]), 8'(n));
  endtask
  task automatic t_slip(input int c);
    int n;
    wr(8'h16, {6'h37, 2'(c)});
    wr(8'h13, {3'h1, 2'h1, 3'(c)});
    @(posedge sys_clk);
    phase_slip <= 1'b1;
    interrupt_status <= 1'b1;
    @(posedge sys_clk);
    phase_slip <= 1'b0;
    #1;
    chk("ipin", 8'(c % 2), 8'(interrupt_output_pin_out));
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n == 1) chk("lpin", 8'((c / 2) % 2), 8'(lock_loss_pin_out));
    end while (lock_loss_status === 1'b1 && n < 200);
    chk("retrig", 8'(RC[c]), 8'(n));
    @(posedge sys_clk);
    interrupt_status <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("lpin", 8'(1 - (c / 2) % 2), 8'(lock_loss_pin_out));
    chk("ipin", 8'(1 - c % 2), 8'(interrupt_output_pin_out));
  endtask
  initial forever #12.5 sys_clk = ~sys_clk;
  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_mon();
    for (int c = 0; c < 4; c++) t_val(c, 1'b0);
    t_val(1, 1'b1);
    for (int c = 0; c < 8; c++) t_slip(c);
    end_sim();
  end
endmodule
bind clock_monitor_alarm_config clock_monitor_alarm_config_props props_u (.sys_clk, .reset_n, .clk_en,
  .reg_addr, .reg_wr, .reg_wdata, .clock_invalid, .offset_monitor_input_enable, .phase_slip,
  .interrupt_status, .first_input_powerdown, .second_input_powerdown, .offset_monitor_active,
  .offset_threshold_select, .clock_alarm, .lock_loss_status, .lock_loss_pin_out, .lock_loss_pin_oe,
  .interrupt_output_pin_out, .interrupt_output_pin_oe);
